// >>> logic/wdac_bcd_down.sv
// four-digit bcd down counter with load
`timescale 1ns/1ps
module wdac_bcd_down
    import wdac_pkg::*;
(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    // control
    input  wire logic        load,
    input  wire logic [15:0] load_val,
    input  wire logic        dec,
    // state
    output logic      [15:0] count
);
    logic [15:0] count_q;
    logic [15:0] dec_val;
    logic [4:0]  borrow;

    assign borrow[0] = 1'b1;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1)
        begin : g_digit
            wire logic [3:0] dig = count_q[gi*4 +: 4];
            assign borrow[gi+1] = borrow[gi] & (dig == 4'h0);
            // digit wraps to nine while borrowing
            assign dec_val[gi*4 +: 4] = !borrow[gi] ? dig :
                (dig == 4'h0) ? 4'h9 : dig - 4'h1; // RULE_21
        end
    endgenerate

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
            count_q <= WDAC_COUNT_RESET;
        else if (load)
            count_q <= load_val;
        else if (dec)
            count_q <= dec_val;
    end

    assign count = count_q;

endmodule : wdac_bcd_down

// >>> logic/wdac_core.sv
// watchdog countdown, reload registers and command register
//
// Notes on behaviour
// [RULE_01] reload held as two bcd bytes
// [RULE_02] reload bytes accessed in any order
// [RULE_03] any reload access restarts count, clears flag
// [RULE_04] count down; alarm when count reaches zero
// [RULE_05] unattended watchdog reloads and alarms repeatedly
// [RULE_06] host touches watchdog within the timeout
// [RULE_07] reload reads return programmed value only
// [RULE_08] both reload bytes zero disables alarm
// [RULE_09] command register decoded at offset 0Bh
// [RULE_10] bit 7 low freezes clock register updates
// [RULE_11] bit 6 swaps alarm routing between outputs
// [RULE_12] bit 5 selects second output drive polarity
// [RULE_13] bit 4 selects pulse of 3 ms
// [RULE_14] bit 3 masks the watchdog interrupt
// [RULE_15] bit 2 masks the clock alarm interrupt
// [RULE_16] bit 1 watchdog flag, cleared by access
// [RULE_17] bit 0 clock alarm flag, cleared by access
// [RULE_18] pulse mode flags read one during pulse
// [RULE_19] reload registers at 0Ch and 0Dh
// [RULE_20] clock alarm register access clears its flag
// [RULE_21] count steps every hundredth second in bcd
`timescale 1ns/1ps
module wdac_core
    import wdac_pkg::*;
#(
    parameter int TICK_CYC  = WDAC_TICK_CYC,
    parameter int PULSE_CYC = WDAC_PULSE_CYC
)
(
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       reset_n,
    // byte bus pins
    input  wire logic       bus_ce_n,
    input  wire logic       bus_oe_n,
    input  wire logic       bus_we_n,
    input  wire logic [5:0] bus_addr,
    input  wire logic [7:0] bus_dq_in,
    output logic      [7:0] bus_dq_out,
    output logic            bus_dq_oe,
    // clock alarm side
    input  wire logic       clock_alarm_evt,
    output logic            clock_update_en,
    // interrupt pins
    output logic            irq_out_first_o,
    output logic            irq_out_first_oe,
    output logic            irq_out_second_o,
    output logic            irq_out_second_oe
);
    // pin synchronisers
    logic [16:0] pin_s1_q;
    logic [16:0] pin_s2_q;
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            pin_s1_q <= {3'h7, 14'h0000};
            pin_s2_q <= {3'h7, 14'h0000};
        end
        else
        begin
            pin_s1_q <= {bus_ce_n, bus_oe_n, bus_we_n, bus_addr, bus_dq_in};
            pin_s2_q <= pin_s1_q;
        end
    end

    wire logic       ce_n_s = pin_s2_q[16];
    wire logic       oe_n_s = pin_s2_q[15];
    wire logic       we_n_s = pin_s2_q[14];
    wire logic [5:0] addr_s = pin_s2_q[13:8];
    wire logic [7:0] data_s = pin_s2_q[7:0];

    // bus cycle tracking
    logic       wr_prev_q;
    logic       rd_prev_q;
    logic [5:0] wr_addr_q;
    logic [7:0] wr_data_q;
    wire logic wr_now = !ce_n_s && !we_n_s;
    wire logic rd_now = !ce_n_s && !oe_n_s && we_n_s;
    // writes commit at the trailing edge, when data is settled
    wire logic wr_commit = wr_prev_q && !wr_now;
    wire logic rd_start  = rd_now && !rd_prev_q;

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            wr_prev_q <= 1'b0;
            rd_prev_q <= 1'b0;
            wr_addr_q <= 6'h00;
            wr_data_q <= 8'h00;
        end
        else
        begin
            wr_prev_q <= wr_now;
            rd_prev_q <= rd_now;
            if (wr_now)
            begin
                wr_addr_q <= addr_s;
                wr_data_q <= data_s;
            end
        end
    end

    // address decoding
    wire logic [5:0] acc_addr = wr_commit ? wr_addr_q : addr_s;
    wire logic       acc_evt  = wr_commit || rd_start;
    wire logic sel_cmd = (acc_addr == WDAC_OFS_CMD); // RULE_09
    wire logic sel_wd1 = (acc_addr == WDAC_OFS_WD_FIRST); // RULE_19
    wire logic sel_wd2 = (acc_addr == WDAC_OFS_WD_SECOND); // RULE_19
    wire logic sel_alm = (acc_addr == WDAC_OFS_TOD_ALM_MIN)
                      || (acc_addr == WDAC_OFS_TOD_ALM_HR)
                      || (acc_addr == WDAC_OFS_TOD_ALM_DAY);
    // reads and writes alike restart the watchdog
    wire logic wd_touch  = acc_evt && (sel_wd1 || sel_wd2); // RULE_03
    wire logic alm_touch = acc_evt && sel_alm; // RULE_20
    wire logic cmd_wr    = wr_commit && sel_cmd;

    // registers
    logic [7:0] cmd_q;
    logic [7:0] wd_first_q;
    logic [7:0] wd_second_q;
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            cmd_q       <= WDAC_CMD_RESET;
            wd_first_q  <= WDAC_RELOAD_RESET;
            wd_second_q <= WDAC_RELOAD_RESET;
        end
        else if (wr_commit)
        begin
            // flag bits are read only and never stored here
            if (sel_cmd)
                cmd_q <= {wr_data_q[7:2], 2'b00}; // RULE_09
            if (sel_wd1)
                wd_first_q <= wr_data_q; // RULE_02
            if (sel_wd2)
                wd_second_q <= wr_data_q; // RULE_02
        end
    end

    wire logic upd_en     = cmd_q[WDAC_BIT_UPDATE_FREEZE_N];
    wire logic route_swap = cmd_q[WDAC_BIT_ROUTE_SWAP];
    wire logic second_pol = cmd_q[WDAC_BIT_SECOND_POL];
    wire logic pulse_sel  = cmd_q[WDAC_BIT_PULSE_SEL];
    wire logic wdog_mask  = cmd_q[WDAC_BIT_WDOG_MASK];
    wire logic clock_mask = cmd_q[WDAC_BIT_CLOCK_MASK];

    // load value seen with a same-cycle write already applied
    wire logic [15:0] wd_reload = {wd_second_q, wd_first_q}; // RULE_01
    wire logic [15:0] wd_load_val =
        {(cmd_wr || !(wr_commit && sel_wd2)) ? wd_second_q : wr_data_q,
         (cmd_wr || !(wr_commit && sel_wd1)) ? wd_first_q : wr_data_q};
    wire logic wd_enabled = (wd_reload != WDAC_COUNT_RESET); // RULE_08

    // hundredth-second tick
    logic [WDAC_CNT_W-1:0] tick_cnt_q;
    wire logic tick = (tick_cnt_q == '0);
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n || tick)
            tick_cnt_q <= WDAC_CNT_W'(TICK_CYC - 1); // RULE_21
        else
            tick_cnt_q <= tick_cnt_q - 1'b1;
    end

    // watchdog countdown
    logic [15:0] wd_count;
    wire logic wd_expire = tick && wd_enabled && !wd_touch
                        && (wd_count == WDAC_COUNT_ONE); // RULE_04
    wire logic wd_evt = wd_expire;

    wdac_bcd_down u_count (
        .ref_clk  (ref_clk),
        .reset_n  (reset_n),
        .load     (wd_touch || wd_expire), // RULE_05
        .load_val (wd_load_val),
        .dec      (tick && wd_enabled && (wd_count != WDAC_COUNT_RESET)),
        .count    (wd_count)
    );

    // alarm channels
    wire logic [WDAC_NUM_CH-1:0] ch_evt  = {clock_alarm_evt, wd_evt};
    wire logic [WDAC_NUM_CH-1:0] ch_clr  = {alm_touch, wd_touch};
    wire logic [WDAC_NUM_CH-1:0] ch_mask = {clock_mask, wdog_mask};
    logic [WDAC_NUM_CH-1:0] ch_flag;
    logic [WDAC_NUM_CH-1:0] ch_pulse;
    logic [WDAC_NUM_CH-1:0] ch_active;

    genvar ci;
    generate
        for (ci = 0; ci < WDAC_NUM_CH; ci = ci + 1)
        begin : g_chan
            wdac_irq_chan #(
                .PULSE_CYC (PULSE_CYC)
            ) u_chan (
                .ref_clk    (ref_clk),
                .reset_n    (reset_n),
                .evt        (ch_evt[ci]),
                .clr        (ch_clr[ci]), // RULE_16
                .pulse_mode (pulse_sel),
                .mask       (ch_mask[ci]), // RULE_14
                .flag_rd    (ch_flag[ci]),
                .pulse_on   (ch_pulse[ci]),
                .active     (ch_active[ci])
            );
        end
    endgenerate

    wire logic wd_flag_rd    = ch_flag[WDAC_CH_WDOG]; // RULE_16
    wire logic clock_flag_rd = ch_flag[WDAC_CH_CLOCK]; // RULE_17
    wire logic wd_act        = ch_active[WDAC_CH_WDOG];
    wire logic clock_act     = ch_active[WDAC_CH_CLOCK]; // RULE_15

    // routing: swap set puts the clock alarm on the first output
    wire logic first_act  = route_swap ? clock_act : wd_act; // RULE_11
    wire logic second_act = route_swap ? wd_act : clock_act; // RULE_11

    // read data; the running count is never on the bus
    wire logic [7:0] cmd_rd = {cmd_q[7:2], wd_flag_rd, clock_flag_rd};
    wire logic mapped = (addr_s == WDAC_OFS_CMD)
                     || (addr_s == WDAC_OFS_WD_FIRST)
                     || (addr_s == WDAC_OFS_WD_SECOND);
    wire logic [7:0] rd_mux =
        (addr_s == WDAC_OFS_CMD)      ? cmd_rd :
        (addr_s == WDAC_OFS_WD_FIRST) ? wd_first_q : // RULE_07
        (addr_s == WDAC_OFS_WD_SECOND) ? wd_second_q : 8'h00;

    // output flops
    logic [7:0] dq_out_q;
    logic       dq_oe_q;
    logic       upd_q;
    logic       first_oe_q;
    logic       second_o_q;
    logic       second_oe_q;
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            dq_out_q    <= 8'h00;
            dq_oe_q     <= 1'b0;
            upd_q       <= WDAC_CMD_RESET[WDAC_BIT_UPDATE_FREEZE_N];
            first_oe_q  <= 1'b0;
            second_o_q  <= 1'b0;
            second_oe_q <= 1'b0;
        end
        else
        begin
            dq_out_q    <= rd_mux;
            dq_oe_q     <= rd_now && mapped;
            upd_q       <= upd_en; // RULE_10
            // first output is open drain, pulled low when active
            first_oe_q  <= first_act;
            // sourcing drives the pin always; sinking is open drain
            second_o_q  <= second_pol ? second_act : 1'b0; // RULE_12
            second_oe_q <= second_pol ? 1'b1 : second_act; // RULE_12
        end
    end

    assign bus_dq_out        = dq_out_q;
    assign bus_dq_oe         = dq_oe_q;
    assign clock_update_en   = upd_q;
    assign irq_out_first_o   = 1'b0;
    assign irq_out_first_oe  = first_oe_q;
    assign irq_out_second_o  = second_o_q;
    assign irq_out_second_oe = second_oe_q;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    property p_touch_reload;
        wd_touch |=> (wd_count == $past(wd_load_val)) && !wd_flag_rd;
    endproperty
    a_touch_reload: assert property (p_touch_reload) // RULE_03
        else $error("watchdog access did not restart count");

    property p_expire;
        tick && wd_enabled && !wd_touch && wd_count == WDAC_COUNT_ONE
            |=> wd_flag_rd ##1 (irq_out_first_oe || $past(wdog_mask)
                                || $past(route_swap));
    endproperty
    a_expire: assert property (p_expire) // RULE_04
        else $error("watchdog did not fire at zero");

    property p_repeat;
        wd_evt |=> wd_count == $past(wd_reload);
    endproperty
    a_repeat: assert property (p_repeat) // RULE_05
        else $error("watchdog did not reload after expiry");

    property p_disabled;
        !wd_enabled |-> !wd_flag_rd;
    endproperty
    a_disabled: assert property (p_disabled) // RULE_08
        else $error("zero reload still raised alarm");

    property p_read_reload;
        rd_now && addr_s == WDAC_OFS_WD_SECOND
            |=> bus_dq_oe && bus_dq_out == $past(wd_second_q);
    endproperty
    a_read_reload: assert property (p_read_reload) // RULE_07
        else $error("reload read returned wrong value");

    property p_route;
        route_swap |=> irq_out_first_oe == $past(clock_act);
    endproperty
    a_route: assert property (p_route) // RULE_11
        else $error("first interrupt routing wrong");

    property p_wdog_mask;
        wdog_mask && !route_swap |=> !irq_out_first_oe;
    endproperty
    a_wdog_mask: assert property (p_wdog_mask) // RULE_14
        else $error("masked watchdog drove its output");

    property p_pulse_flag;
        pulse_sel && !ch_pulse[WDAC_CH_WDOG] && rd_now
            && addr_s == WDAC_OFS_CMD |=> !bus_dq_out[1];
    endproperty
    a_pulse_flag: assert property (p_pulse_flag) // RULE_18
        else $error("flag set outside pulse");

    property p_alm_clear;
        alm_touch && !clock_alarm_evt |=> !clock_flag_rd;
    endproperty
    a_alm_clear: assert property (p_alm_clear) // RULE_20
        else $error("alarm register access left flag set");

    property p_freeze;
        cmd_wr |=> ##1 clock_update_en == $past(wr_data_q[7], 2);
    endproperty
    a_freeze: assert property (p_freeze) // RULE_10
        else $error("update enable did not follow command");

    // sourcing mode keeps the second pin driven even when idle
    property p_second_drive;
        second_pol |=> irq_out_second_oe;
    endproperty
    a_second_drive: assert property (p_second_drive) // RULE_12
        else $error("sourcing second output not driven");

    property p_clock_mask;
        clock_mask && route_swap |=> !irq_out_first_oe;
    endproperty
    a_clock_mask: assert property (p_clock_mask) // RULE_15
        else $error("masked clock alarm drove its output");

endmodule : wdac_core

// >>> logic/wdac_irq_chan.sv
// one alarm channel: sticky flag, pulse stretch and mask
`timescale 1ns/1ps
module wdac_irq_chan
    import wdac_pkg::*;
#(
    parameter int PULSE_CYC = WDAC_PULSE_CYC
)
(
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic reset_n,
    // events and control
    input  wire logic evt,
    input  wire logic clr,
    input  wire logic pulse_mode,
    input  wire logic mask,
    // state
    output logic      flag_rd,
    output logic      pulse_on,
    output logic      active
);
    logic                  flag_q;
    logic                  pulse_q;
    logic [WDAC_CNT_W-1:0] pcnt_q;
    wire  logic            pulse_done = pulse_q && (pcnt_q == '0);

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            flag_q  <= 1'b0;
            pulse_q <= 1'b0;
            pcnt_q  <= '0;
        end
        else if (evt)
        begin
            // a new event wins over a clear in the same cycle
            flag_q  <= 1'b1;
            pulse_q <= 1'b1;
            pcnt_q  <= WDAC_CNT_W'(PULSE_CYC - 1); // RULE_13
        end
        else if (clr)
        begin
            flag_q  <= 1'b0;
            pulse_q <= 1'b0;
        end
        else if (pulse_q)
        begin
            pcnt_q  <= pcnt_q - 1'b1;
            pulse_q <= !pulse_done;
            // pulse mode drops the flag with the pulse
            flag_q  <= flag_q && !(pulse_mode && pulse_done); // RULE_18
        end
    end

    assign pulse_on = pulse_q;
    assign flag_rd  = pulse_mode ? (pulse_q && flag_q) : flag_q; // RULE_18
    assign active   = !mask && (pulse_mode ? pulse_q : flag_q); // RULE_13

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    property p_pulse_min;
        $rose(pulse_q) && !clr |-> pulse_q [*8];
    endproperty
    a_pulse_min: assert property (p_pulse_min) // RULE_13
        else $error("alarm pulse ended too soon");

endmodule : wdac_irq_chan

// >>> pkg/wdac_pkg.sv
// constants shared by the watchdog alarm and command block
package wdac_pkg;

    // register offsets on the byte bus
    localparam logic [5:0] WDAC_OFS_TOD_ALM_MIN = 6'h03;
    localparam logic [5:0] WDAC_OFS_TOD_ALM_HR  = 6'h05;
    localparam logic [5:0] WDAC_OFS_TOD_ALM_DAY = 6'h07;
    localparam logic [5:0] WDAC_OFS_CMD         = 6'h0B;
    localparam logic [5:0] WDAC_OFS_WD_FIRST    = 6'h0C;
    localparam logic [5:0] WDAC_OFS_WD_SECOND   = 6'h0D;

    // command register field positions
    localparam int WDAC_BIT_UPDATE_FREEZE_N = 7;
    localparam int WDAC_BIT_ROUTE_SWAP      = 6;
    localparam int WDAC_BIT_SECOND_POL      = 5;
    localparam int WDAC_BIT_PULSE_SEL       = 4;
    localparam int WDAC_BIT_WDOG_MASK       = 3;
    localparam int WDAC_BIT_CLOCK_MASK      = 2;

    // values after reset
    localparam logic [7:0]  WDAC_CMD_RESET    = 8'h8C;
    localparam logic [7:0]  WDAC_RELOAD_RESET = 8'h00;
    localparam logic [15:0] WDAC_COUNT_RESET  = 16'h0000;
    localparam logic [15:0] WDAC_COUNT_ONE    = 16'h0001;

    // alarm channel indices
    localparam int WDAC_CH_WDOG  = 0;
    localparam int WDAC_CH_CLOCK = 1;
    localparam int WDAC_NUM_CH   = 2;

    // timing
    localparam int WDAC_CLK_PERIOD_NS = 40;
    localparam int WDAC_TICK_TIME_MS  = 10;
    localparam int WDAC_PULSE_TIME_MS = 3;
    localparam int WDAC_TICK_CYC  =
        (WDAC_TICK_TIME_MS * 1000000) / WDAC_CLK_PERIOD_NS;
    localparam int WDAC_PULSE_CYC =
        (WDAC_PULSE_TIME_MS * 1000000 + WDAC_CLK_PERIOD_NS - 1)
        / WDAC_CLK_PERIOD_NS;
    localparam int WDAC_CNT_W = 18;

endpackage : wdac_pkg

// >>> verif/wdac_core_bench.sv
// self-checking bench for the watchdog and command register block
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin failures++; \
    $display("Error at %0t: got %h exp %h", $time, (g), (e)); end end
module wdac_core_bench
    import wdac_pkg::*;
;
    localparam int TICK  = 20;
    localparam int PULSE = 10;

    logic       ref_clk;
    logic       reset_n;
    logic       ce_n;
    logic       oe_n;
    logic       we_n;
    logic [5:0] addr;
    logic [7:0] dq_in;
    logic [7:0] dq_out;
    logic       dq_oe;
    logic       evt;
    logic       upd_en;
    logic       first_o;
    logic       first_oe;
    logic       second_o;
    logic       second_oe;
    logic [7:0] cmd;
    logic [7:0] rdat;
    logic       roe;
    logic [1:0] exp_act;
    logic       act1;
    logic       act2;
    int         n;
    int         failures;
    int         n_tests;
    logic [7:0] cmds [5] = '{8'h80, 8'hC0, 8'hE0, 8'hA0, 8'h88};
    logic [5:0] tods [3] = '{WDAC_OFS_TOD_ALM_MIN, WDAC_OFS_TOD_ALM_HR,
                             WDAC_OFS_TOD_ALM_DAY};

    // active level of the second pin depends on its drive polarity
    assign act1 = first_oe;
    assign act2 = second_oe & (cmd[5] ? second_o : ~second_o);

    wdac_core #(.TICK_CYC(TICK), .PULSE_CYC(PULSE)) i_dut (
        .ref_clk(ref_clk), .reset_n(reset_n), .bus_ce_n(ce_n),
        .bus_oe_n(oe_n), .bus_we_n(we_n), .bus_addr(addr),
        .bus_dq_in(dq_in), .bus_dq_out(dq_out), .bus_dq_oe(dq_oe),
        .clock_alarm_evt(evt), .clock_update_en(upd_en),
        .irq_out_first_o(first_o), .irq_out_first_oe(first_oe),
        .irq_out_second_o(second_o), .irq_out_second_oe(second_oe));

    wdac_host i_host (
        .ref_clk(ref_clk), .bus_dq_out(dq_out), .bus_dq_oe(dq_oe),
        .bus_ce_n(ce_n), .bus_oe_n(oe_n), .bus_we_n(we_n),
        .bus_addr(addr), .bus_dq_in(dq_in));

    initial
        ref_clk = 1'b0;
    always #20 ref_clk = ~ref_clk;

    task automatic finish_test;
        $display("TB: %0d mismatches in %0d checks", failures, n_tests);
        if (failures == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : finish_test

    task automatic chk_rd(input logic [5:0] a, input logic [7:0] e);
        i_host.rd(a, rdat, roe);
        `CHK(roe, 1'b1);
        `CHK(rdat, e);
    endtask : chk_rd

    task automatic wr_cmd(input logic [7:0] v);
        cmd = v;
        i_host.wr(WDAC_OFS_CMD, v);
    endtask : wr_cmd

    task automatic wait_act(input int lim);
        n = 0;
        while ((act1 | act2) !== 1'b1 && n < lim)
        begin
            @(negedge ref_clk);
            n++;
        end
    endtask : wait_act

    task automatic pulse_evt;
        @(negedge ref_clk);
        evt = 1'b1;
        @(negedge ref_clk);
        evt = 1'b0;
    endtask : pulse_evt

    // whole run needs about 3200 cycles
    initial
    begin
        #(40 * 10000);
        failures++;
        finish_test();
    end

    initial
    begin
        failures = 0;
        n_tests  = 0;
        reset_n  = 1'b0;
        evt      = 1'b0;
        cmd      = 8'h8C;
        repeat (16) @(negedge ref_clk);
        reset_n = 1'b1;
        `CHK(upd_en, 1'b1);
        `CHK({act1, act2}, 2'b00);
        `CHK(first_o, 1'b0);
        chk_rd(WDAC_OFS_CMD, 8'h8C);
        chk_rd(WDAC_OFS_WD_FIRST, 8'h00);
        chk_rd(WDAC_OFS_WD_SECOND, 8'h00);
        i_host.rd(6'h0E, rdat, roe);
        `CHK(roe, 1'b0);
        // flag bits are status only, a write there must not stick
        wr_cmd(8'h7F);
        `CHK(upd_en, 1'b0);
        chk_rd(WDAC_OFS_CMD, 8'h7C);
        wr_cmd(8'h80);
        `CHK(upd_en, 1'b1);
        i_host.wr(WDAC_OFS_WD_SECOND, 8'h12);
        i_host.wr(WDAC_OFS_WD_FIRST, 8'h34);
        chk_rd(WDAC_OFS_WD_FIRST, 8'h34);
        chk_rd(WDAC_OFS_WD_SECOND, 8'h12);
        // 1.00 s is 100 ticks only if the count borrows in bcd
        i_host.wr(WDAC_OFS_WD_SECOND, 8'h01);
        i_host.wr(WDAC_OFS_WD_FIRST, 8'h00);
        wait_act(110 * TICK);
        `CHK(n >= 99 * TICK - 12 && n <= 100 * TICK + 4, 1'b1);
        `CHK(act1, 1'b1);
        chk_rd(WDAC_OFS_CMD, 8'h82);
        chk_rd(WDAC_OFS_WD_FIRST, 8'h00);
        `CHK(act1, 1'b0);
        chk_rd(WDAC_OFS_CMD, 8'h80);
        i_host.wr(WDAC_OFS_WD_SECOND, 8'h00);
        i_host.wr(WDAC_OFS_WD_FIRST, 8'h03);
        foreach (cmds[i])
        begin
            wr_cmd(cmds[i]);
            chk_rd(WDAC_OFS_WD_SECOND, 8'h00);
            exp_act = cmds[i][3] ? 2'b00 : {~cmds[i][6], cmds[i][6]};
            wait_act(4 * TICK);
            `CHK({act1, act2}, exp_act);
            chk_rd(WDAC_OFS_CMD, cmds[i] | 8'h02);
            chk_rd(WDAC_OFS_WD_SECOND, 8'h00);
            `CHK({act1, act2}, 2'b00);
        end
        wr_cmd(8'h90);
        chk_rd(WDAC_OFS_WD_FIRST, 8'h03);
        wait_act(4 * TICK);
        n = 0;
        while (act1 === 1'b1 && n < 4 * PULSE)
        begin
            @(negedge ref_clk);
            n++;
        end
        `CHK(n, PULSE);
        chk_rd(WDAC_OFS_CMD, 8'h90);
        wait_act(4 * TICK);
        `CHK(act1, 1'b1);
        chk_rd(WDAC_OFS_CMD, 8'h92);
        i_host.wr(WDAC_OFS_WD_FIRST, 8'h00);
        wait_act(6 * TICK);
        `CHK(n, 6 * TICK);
        chk_rd(WDAC_OFS_CMD, 8'h90);
        wr_cmd(8'hC0);
        foreach (tods[i])
        begin
            pulse_evt();
            wait_act(8);
            `CHK(act1, 1'b1);
            chk_rd(WDAC_OFS_CMD, 8'hC1);
            i_host.rd(tods[i], rdat, roe);
            `CHK(act1, 1'b0);
            chk_rd(WDAC_OFS_CMD, 8'hC0);
        end
        wr_cmd(8'hC4);
        pulse_evt();
        wait_act(8);
        `CHK(n, 8);
        chk_rd(WDAC_OFS_CMD, 8'hC5);
        i_host.wr(WDAC_OFS_TOD_ALM_DAY, 8'h00);
        chk_rd(WDAC_OFS_CMD, 8'hC4);
        finish_test();
    end

endmodule : wdac_core_bench

// >>> verif/wdac_host.sv
// host processor model driving the byte-wide bus pins
`timescale 1ns/1ps
module wdac_host
    import wdac_pkg::*;
(
    // clock
    input  wire logic       ref_clk,
    // device read side
    input  wire logic [7:0] bus_dq_out,
    input  wire logic       bus_dq_oe,
    // bus pins
    output logic            bus_ce_n,
    output logic            bus_oe_n,
    output logic            bus_we_n,
    output logic      [5:0] bus_addr,
    output logic      [7:0] bus_dq_in
);
    logic       drv;
    logic [7:0] wdat;
    logic [7:0] idle_pat;

    // released lines toggle so a stale byte never passes for data
    assign bus_dq_in = bus_dq_oe ? bus_dq_out : drv ? wdat : idle_pat;

    initial
    begin
        bus_ce_n = 1'b1;
        bus_oe_n = 1'b1;
        bus_we_n = 1'b1;
        bus_addr = 6'h00;
        drv      = 1'b0;
        wdat     = 8'h00;
        idle_pat = 8'h5A;
    end

    always @(negedge ref_clk)
        idle_pat <= ~idle_pat;

    // write phases held 4 cycles, read phases 5, gaps 5: pins pass a 2-flop sync
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        bus_addr = a;
        wdat     = d;
        drv      = 1'b1;
        bus_ce_n = 1'b0;
        bus_we_n = 1'b0;
        repeat (4) @(negedge ref_clk);
        bus_we_n = 1'b1;
        bus_ce_n = 1'b1;
        repeat (5) @(negedge ref_clk);
        drv = 1'b0;
    endtask : wr

    task automatic rd(input logic [5:0] a, output logic [7:0] d,
                      output logic oe);
        @(negedge ref_clk);
        bus_addr = a;
        bus_ce_n = 1'b0;
        bus_oe_n = 1'b0;
        repeat (5) @(negedge ref_clk);
        d        = bus_dq_out;
        oe       = bus_dq_oe;
        bus_ce_n = 1'b1;
        bus_oe_n = 1'b1;
        repeat (5) @(negedge ref_clk);
    endtask : rd

endmodule : wdac_host
